// [rtl/gpac_ports.sv]
// How it works
// - Port C direction bit one turns that pin's driver off, making it input.
// - Port C direction bit zero drives the stored data latch onto the pin.
// - An enabled peripheral on a port C pin overrides the direction bit.
// - A peripheral output enable counts only while its pin select is active.
// - Port C data latch is not reset; port C direction resets to all ones.
// - Port A has six bits, upper bits read zero, direction resets to ones.
// - Port A bit 4 feeds timer 0 clock and drives open drain only.
// - Port A bits 0 to 3 may be analog inputs, bit 3 reference.
// - Port A bit 5 is the serial slave select input or analog input.
// - Port C bits 0 and 1 carry timer 1 oscillator and capture two.
// - Port C bit 2 carries capture, compare and PWM one.
// - Port C bit 3 carries the synchronous serial clock.
// - Port C bit 4 carries SPI data in or I2C data line.
// - Port C bit 5 carries synchronous serial data out.
// - Port C bits 6 and 7 carry USART transmit and receive.
module gpac_ports (
	input wire logic clk_in, // core clock, 10 MHz
	input wire logic rst_b_in, // synchronous reset, active low
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB access phase
	input wire logic pwrite_in, // APB direction, high for write
	input wire logic [gpac_pkg::ADDR_W-1:0] paddr_in, // APB byte address
	input wire logic [31:0] pwdata_in, // APB write data
	input wire logic [3:0] pstrb_in, // APB byte strobes
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error, unmapped address
	input wire logic [5:0] port_a_pin_in, // port A pad levels
	output logic [5:0] port_a_pin_out, // port A pad drive value
	output logic [5:0] port_a_pin_oe_out, // port A pad drive enable
	input wire logic [7:0] port_c_pin_in, // port C pad levels
	output logic [7:0] port_c_pin_out, // port C pad drive value
	output logic [7:0] port_c_pin_oe_out, // port C pad drive enable
	input wire logic [7:0] periph_select_in, // peripheral owns port C pin
	input wire logic [7:0] periph_oe_in, // peripheral wants to drive pin
	input wire logic [7:0] periph_data_in, // peripheral drive value
	output logic [7:0] periph_pin_level_out, // settled port C levels to peripherals
	output logic timer0_clock_out, // settled timer 0 clock input
	output logic serial_select_b_out, // settled slave select, active low
	output logic [5:0] analog_select_out, // port A pins routed to converter
	output logic vref_select_out // port A bit 3 used as reference
);

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [gpac_pkg::ADDR_W-1:0] ADDR_A_DATA = gpac_pkg::gpac_byte_addr(gpac_pkg::PORT_A_DATA_IDX);
	localparam logic [gpac_pkg::ADDR_W-1:0] ADDR_C_DATA = gpac_pkg::gpac_byte_addr(gpac_pkg::PORT_C_DATA_IDX);
	localparam logic [gpac_pkg::ADDR_W-1:0] ADDR_A_DIR = gpac_pkg::gpac_byte_addr(gpac_pkg::PORT_A_DIRECTION_IDX);
	localparam logic [gpac_pkg::ADDR_W-1:0] ADDR_C_DIR = gpac_pkg::gpac_byte_addr(gpac_pkg::PORT_C_DIRECTION_IDX);
	localparam logic [gpac_pkg::ADDR_W-1:0] ADDR_CFG = gpac_pkg::gpac_byte_addr(gpac_pkg::ANALOG_PIN_CONFIG_IDX);

	// ----------------------------------------
	// State
	// ----------------------------------------
	gpac_pkg::gpac_bus_state_type bus_state;
	logic [5:0] port_a_data;
	logic [7:0] port_c_data;
	logic [5:0] port_a_direction;
	logic [7:0] port_c_direction;
	logic [2:0] analog_config_field;
	logic [5:0] port_a_level;
	logic [7:0] port_c_level;
	logic [5:0] analog_mask;
	logic vref_mode;
	logic access;
	logic commit;
	logic write_low;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [7:0] next_c_oe;
	logic [7:0] next_c_out;
	logic [5:0] next_a_oe;
	logic [5:0] next_a_out;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Pins taken by the converter for each analog config code
	function automatic logic [5:0] analog_pins(input logic [2:0] cfg);
		logic [5:0] mask;
		mask = 6'h00;
		case (cfg)
			3'h0: mask = 6'h2f;
			3'h1: mask = 6'h2f;
			3'h2: mask = 6'h2b;
			3'h3: mask = 6'h2b;
			3'h4: mask = 6'h0b;
			3'h5: mask = 6'h0b;
			default: mask = 6'h00;
		endcase
		analog_pins = mask;
	endfunction : analog_pins

	// Config codes whose bit 3 serves as converter reference
	function automatic logic uses_vref(input logic [2:0] cfg);
		uses_vref = (cfg == 3'h1) || (cfg == 3'h3) || (cfg == 3'h5);
	endfunction : uses_vref

	// Digital read value: analog pins read as zero
	function automatic logic [5:0] digital_view(input logic [5:0] level, input logic [5:0] mask);
		digital_view = level & ~mask;
	endfunction : digital_view

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Port A pads pass the three-stage filter
	gpac_pin_sync #(
		.WIDTH(gpac_pkg::PORT_A_W)
	) u_sync_a (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.pin_in(port_a_pin_in),
		.level_out(port_a_level)
	);

	// Port C pads pass the three-stage filter
	gpac_pin_sync #(
		.WIDTH(gpac_pkg::PORT_C_W)
	) u_sync_c (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.pin_in(port_c_pin_in),
		.level_out(port_c_level)
	);

	// ----------------------------------------
	// Analog configuration decode
	// ----------------------------------------
	// Analog pin selection
	assign analog_mask = analog_pins(analog_config_field);
	assign vref_mode = uses_vref(analog_config_field);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Access phase seen; commit only on the ready edge
	assign access = psel_in && penable_in;
	assign commit = access && (bus_state == gpac_pkg::GPAC_DONE);
	assign write_low = commit && pwrite_in && pstrb_in[0];

	// One wait state keeps read data and ready straight from flops
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			bus_state <= gpac_pkg::GPAC_IDLE;
		end else begin
			case (bus_state)
				gpac_pkg::GPAC_IDLE: begin
					if (access) begin
						bus_state <= gpac_pkg::GPAC_DONE;
					end
				end
				gpac_pkg::GPAC_DONE: begin
					bus_state <= gpac_pkg::GPAC_WAIT;
				end
				gpac_pkg::GPAC_WAIT: begin
					bus_state <= gpac_pkg::GPAC_IDLE;
				end
				default: begin
					bus_state <= gpac_pkg::GPAC_IDLE;
				end
			endcase
		end
	end

	// Ready rises for exactly the answering cycle
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pready_out <= 1'b0;
		end else begin
			pready_out <= access && (bus_state == gpac_pkg::GPAC_IDLE);
		end
	end

	// Read mux and address check
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (paddr_in == ADDR_A_DATA) begin
			next_prdata = {26'h000_0000, digital_view(port_a_level, analog_mask)};
		end else if (paddr_in == ADDR_C_DATA) begin
			next_prdata = {24'h00_0000, port_c_level};
		end else if (paddr_in == ADDR_A_DIR) begin
			next_prdata = {26'h000_0000, port_a_direction};
		end else if (paddr_in == ADDR_C_DIR) begin
			next_prdata = {24'h00_0000, port_c_direction};
		end else if (paddr_in == ADDR_CFG) begin
			next_prdata = {29'h0000_0000, analog_config_field};
		end else begin
			next_pslverr = 1'b1;
		end
	end

	// Read data and error are loaded with ready, cleared otherwise
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else if (access && (bus_state == gpac_pkg::GPAC_IDLE)) begin
			prdata_out <= pwrite_in ? 32'h0000_0000 : next_prdata;
			pslverr_out <= next_pslverr;
		end else begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Data latches
	// ----------------------------------------
	// Latches hold through every reset, unknown from power-up
	always_ff @(posedge clk_in) begin
		if (write_low && (paddr_in == ADDR_A_DATA)) begin
			port_a_data <= pwdata_in[5:0];
		end
	end

	// Port C latch is written only by software
	always_ff @(posedge clk_in) begin
		if (write_low && (paddr_in == ADDR_C_DATA)) begin
			port_c_data <= pwdata_in[7:0];
		end
	end

	// ----------------------------------------
	// Direction and configuration registers
	// ----------------------------------------
	// Port A direction all ones after reset
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			port_a_direction <= gpac_pkg::PORT_A_DIRECTION_RST;
		end else if (write_low && (paddr_in == ADDR_A_DIR)) begin
			port_a_direction <= pwdata_in[5:0];
		end
	end

	// Port C direction all ones after reset
	// Stored bit is software's; overrides never alter it
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			port_c_direction <= gpac_pkg::PORT_C_DIRECTION_RST;
		end else if (write_low && (paddr_in == ADDR_C_DIR)) begin
			port_c_direction <= pwdata_in[7:0];
		end
	end

	// Config field is plain storage; code choice rests with software
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			analog_config_field <= gpac_pkg::ANALOG_CONFIG_RST;
		end else if (write_low && (paddr_in == ADDR_CFG)) begin
			analog_config_field <= pwdata_in[2:0];
		end
	end

	// ----------------------------------------
	// Port C drive
	// ----------------------------------------
	// Each pin's owner picks direction and value
	always_comb begin
		next_c_oe = 8'h00;
		next_c_out = 8'h00;
		for (int i = 0; i < gpac_pkg::PORT_C_W; i++) begin
			if (periph_select_in[i]) begin
				next_c_oe[i] = periph_oe_in[i];
				next_c_out[i] = periph_oe_in[i] & periph_data_in[i];
			end else if (!port_c_direction[i]) begin
				next_c_oe[i] = 1'b1;
				next_c_out[i] = port_c_data[i];
			end else begin
				next_c_oe[i] = 1'b0;
				next_c_out[i] = 1'b0;
			end
		end
	end

	// Registered pad controls for port C
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			port_c_pin_oe_out <= 8'h00;
			port_c_pin_out <= 8'h00;
		end else begin
			port_c_pin_oe_out <= next_c_oe;
			port_c_pin_out <= next_c_out;
		end
	end

	// Settled levels handed to the peripherals sharing port C
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			periph_pin_level_out <= 8'h00;
		end else begin
			periph_pin_level_out <= port_c_level;
		end
	end

	// ----------------------------------------
	// Port A drive
	// ----------------------------------------
	// Push-pull except bit 4; analog pins are never driven
	always_comb begin
		next_a_oe = 6'h00;
		next_a_out = 6'h00;
		for (int i = 0; i < gpac_pkg::PORT_A_W; i++) begin
			if (port_a_direction[i] || analog_mask[i]) begin
				next_a_oe[i] = 1'b0;
				next_a_out[i] = 1'b0;
			end else if (i == gpac_pkg::TIMER0_CLOCK_BIT) begin
				next_a_oe[i] = ~port_a_data[i];
				next_a_out[i] = 1'b0;
			end else begin
				next_a_oe[i] = 1'b1;
				next_a_out[i] = port_a_data[i];
			end
		end
	end

	// Registered pad controls for port A
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			port_a_pin_oe_out <= 6'h00;
			port_a_pin_out <= 6'h00;
		end else begin
			port_a_pin_oe_out <= next_a_oe;
			port_a_pin_out <= next_a_out;
		end
	end

	// ----------------------------------------
	// Port A shared inputs
	// ----------------------------------------
	// Timer 0 clock from bit 4 level
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			timer0_clock_out <= 1'b0;
		end else begin
			timer0_clock_out <= port_a_level[gpac_pkg::TIMER0_CLOCK_BIT];
		end
	end

	// Slave select reads high (inactive) while bit 5 is analog
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			serial_select_b_out <= 1'b1;
		end else begin
			serial_select_b_out <= port_a_level[gpac_pkg::SERIAL_SELECT_BIT]
				| analog_mask[gpac_pkg::SERIAL_SELECT_BIT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			analog_select_out <= 6'h00;
			vref_select_out <= 1'b0;
		end else begin
			analog_select_out <= analog_mask;
			vref_select_out <= vref_mode;
		end
	end

endmodule : gpac_ports

// [rtl/gpac_pkg.sv]
package gpac_pkg;

	// ----------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------
	// Printed offsets are word indices; byte address is four times the index
	localparam logic [7:0] PORT_A_DATA_IDX = 8'h05;
	localparam logic [7:0] PORT_C_DATA_IDX = 8'h07;
	localparam logic [7:0] PORT_A_DIRECTION_IDX = 8'h85;
	localparam logic [7:0] PORT_C_DIRECTION_IDX = 8'h87;
	localparam logic [7:0] ANALOG_PIN_CONFIG_IDX = 8'h9f;
	localparam int ADDR_W = 12;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int PORT_A_W = 6;
	localparam int PORT_C_W = 8;
	localparam int CFG_W = 3;
	localparam logic [5:0] PORT_A_DIRECTION_RST = 6'h3f;
	localparam logic [7:0] PORT_C_DIRECTION_RST = 8'hff;
	localparam logic [2:0] ANALOG_CONFIG_RST = 3'h0;

	// ----------------------------------------
	// Pin positions of shared functions
	// ----------------------------------------
	localparam int VREF_BIT = 3;
	localparam int TIMER0_CLOCK_BIT = 4;
	localparam int SERIAL_SELECT_BIT = 5;

	// ----------------------------------------
	// Bus answer timing
	// ----------------------------------------
	localparam int APB_WAIT_CYCLES = 1;

	// Bus slave phases
	typedef enum logic [1:0] {
		GPAC_IDLE,
		GPAC_WAIT,
		GPAC_DONE
	} gpac_bus_state_type;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] gpac_byte_addr(input logic [7:0] idx);
		gpac_byte_addr = {2'h0, idx, 2'h0};
	endfunction : gpac_byte_addr

endpackage : gpac_pkg

// [rtl/gpac_pin_sync.sv]
// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module gpac_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in, // core clock
	input wire logic rst_b_in, // synchronous reset, active low
	input wire logic [WIDTH-1:0] pin_in, // asynchronous pin levels
	output logic [WIDTH-1:0] level_out // settled pin levels
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Capture chain; first stage feeds only the second
	always_ff @(posedge clk_in) begin
		stage1 <= pin_in;
		stage2 <= stage1;
		stage3 <= stage2;
	end

	// A change counts only once stages two and three agree, filtering one-cycle glitches
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			level_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level_out[i] <= stage3[i];
				end
			end
		end
	end

endmodule : gpac_pin_sync

// [dv/gpac_ports_properties.sv]
module gpac_ports_properties (
	input wire logic clk_in, // core clock
	input wire logic rst_b_in, // reset, active low
	input wire logic psel_in, // select
	input wire logic penable_in, // access phase
	input wire logic [gpac_pkg::ADDR_W-1:0] paddr_in, // byte address
	input wire logic [31:0] prdata_out, // read data
	input wire logic pready_out, // ready
	input wire logic pslverr_out, // error
	input wire logic [5:0] port_a_pin_out, // A drive value
	input wire logic [5:0] port_a_pin_oe_out, // A drive enable
	input wire logic [7:0] port_c_pin_out, // C drive value
	input wire logic [7:0] port_c_pin_oe_out, // C drive enable
	input wire logic [7:0] periph_select_in, // pin owner
	input wire logic [7:0] periph_oe_in, // peripheral enable
	input wire logic [7:0] periph_data_in, // peripheral value
	input wire logic [5:0] analog_select_out, // analog pins
	input wire logic vref_select_out // reference pin
);
	// ----------------------------------------
	// Bus and pad relations
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking

	// No reset here: pads must be off after any reset edge
	reset_off_a: assert property (!rst_b_in |=> port_c_pin_oe_out == 8'h00 && port_a_pin_oe_out == 6'h00)
		else $error("pads driven after reset");
	answer_one_wait_a: assert property (disable iff (!rst_b_in) psel_in && $rose(penable_in) |=> pready_out)
		else $error("no answer after one wait");
	ready_pulse_a: assert property (disable iff (!rst_b_in) pready_out |=> !pready_out)
		else $error("ready held too long");
	error_with_ready_a: assert property (disable iff (!rst_b_in) pslverr_out |-> pready_out)
		else $error("error without ready");
	rdata_idle_a: assert property (disable iff (!rst_b_in) !pready_out |-> prdata_out == 32'h0)
		else $error("read data outside answer");
	port_a_upper_a: assert property (disable iff (!rst_b_in) pready_out && paddr_in == 12'h014 |-> prdata_out[31:6] == 26'h0)
		else $error("port A upper bits not zero");
	// Selected pins follow the peripheral one edge later, whatever direction says
	override_oe_a: assert property (disable iff (!rst_b_in) $past(rst_b_in) |->
		((port_c_pin_oe_out ^ $past(periph_oe_in)) & $past(periph_select_in)) == 8'h00)
		else $error("override enable wrong");
	override_data_a: assert property (disable iff (!rst_b_in) $past(rst_b_in) |->
		((port_c_pin_out ^ $past(periph_oe_in & periph_data_in)) & $past(periph_select_in)) == 8'h00)
		else $error("override value wrong");
	open_drain_a: assert property (disable iff (!rst_b_in) port_a_pin_out[4] == 1'b0)
		else $error("timer pin drives high");
	vref_pin_a: assert property (disable iff (!rst_b_in) analog_select_out[4] == 1'b0 &&
		(vref_select_out -> analog_select_out[3]))
		else $error("analog map wrong");

	override_c: cover property (disable iff (!rst_b_in) (periph_select_in & periph_oe_in) != 8'h00);
	unmapped_c: cover property (disable iff (!rst_b_in) pslverr_out);
	drive_c: cover property (disable iff (!rst_b_in) port_c_pin_oe_out == 8'hff);
endmodule : gpac_ports_properties

// [dv/gpac_pad_model.sv]
module gpac_pad_model (
	input wire logic [5:0] a_drive_in, // block value, port A
	input wire logic [5:0] a_oe_in, // block enable, port A
	input wire logic [5:0] a_ext_in, // outside level, port A
	output logic [5:0] a_level_out, // pad level, port A
	input wire logic [7:0] c_drive_in, // block value, port C
	input wire logic [7:0] c_oe_in, // block enable, port C
	input wire logic [7:0] c_ext_in, // outside level, port C
	output logic [7:0] c_level_out // pad level, port C
);
	// ----------------------------------------
	// Pad resolution
	// ----------------------------------------
	// Block wins where it drives
	assign a_level_out = (a_drive_in & a_oe_in) | (a_ext_in & ~a_oe_in);
	assign c_level_out = (c_drive_in & c_oe_in) | (c_ext_in & ~c_oe_in);
endmodule : gpac_pad_model

// [dv/tb_gpio_ports_a_and_c.sv]
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_gpio_ports_a_and_c;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] q; logic e;} gpac_row_type;
	logic clk_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
	logic [3:0] pstrb_in = 4'hf;
	logic pready_out, pslverr_out, er, t0, ssb, vref;
	logic [5:0] a_pin, a_out, a_oe, asel;
	logic [5:0] a_ext = 6'h00;
	logic [7:0] c_pin, c_out, c_oe, plev;
	logic [7:0] c_ext = 8'h00, sel = 8'h00, poe = 8'h00, pdat = 8'h00;
	logic [5:0] amap [8] = '{6'h2f, 6'h2f, 6'h2b, 6'h2b, 6'h0b, 6'h0b, 6'h00, 6'h00};
	logic [7:0] vmap = 8'h2a;
	gpac_row_type rows [4] = '{'{12'h21c, 8'h5a, 8'h5a, 1'b0}, '{12'h214, 8'hff, 8'h3f, 1'b0},
		'{12'h27c, 8'h05, 8'h05, 1'b0}, '{12'h100, 8'h12, 8'h00, 1'b1}};
	int mismatches = 0, n_checks = 0, cyc = 0;

	always #50 clk_in = ~clk_in;

	gpac_ports dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.port_a_pin_in(a_pin), .port_a_pin_out(a_out), .port_a_pin_oe_out(a_oe),
		.port_c_pin_in(c_pin), .port_c_pin_out(c_out), .port_c_pin_oe_out(c_oe),
		.periph_select_in(sel), .periph_oe_in(poe), .periph_data_in(pdat), .periph_pin_level_out(plev),
		.timer0_clock_out(t0), .serial_select_b_out(ssb), .analog_select_out(asel), .vref_select_out(vref));
	gpac_pad_model pad_u (.a_drive_in(a_out), .a_oe_in(a_oe), .a_ext_in(a_ext), .a_level_out(a_pin),
		.c_drive_in(c_out), .c_oe_in(c_oe), .c_ext_in(c_ext), .c_level_out(c_pin));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= {24'h0, d};
		@(posedge clk_in);
		penable_in <= 1'b1;
		// Hold everything until ready is seen at an edge
		// No cycle count assumed; the hang guard ends a missing answer
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] q);
		apb(1'b0, a, 8'h00);
		`CHK(nm, {24'h0, q}, rd)
	endtask : rchk

	task automatic settle(input int k);
		repeat (k) @(posedge clk_in);
	endtask : settle

	task automatic do_reset;
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		settle(10);
		rst_b_in <= 1'b1;
		settle(3);
	endtask : do_reset

	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			complete_run;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		do_reset;
		rchk("c_dir_rst", 12'h21c, 8'hff);
		rchk("a_dir_rst", 12'h214, 8'h3f);
		`CHK("c_oe_rst", 8'h00, c_oe)
		`CHK("asel_rst", 6'h2f, asel)
		`CHK("ssb_rst", 1'b1, ssb)
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			`CHK("err", rows[i].e, er)
			rchk("readback", rows[i].a, rows[i].q);
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h27c, i[7:0]);
			settle(2);
			`CHK("asel", amap[i], asel)
			`CHK("vref", vmap[i], vref)
		end
		// Config left at 11x while slave select is used
		a_ext <= 6'h0a;
		settle(6);
		rchk("a_dat", 12'h014, 8'h0a);
		`CHK("t0_lo", 1'b0, t0)
		`CHK("ssb_lo", 1'b0, ssb)
		a_ext <= 6'h3a;
		settle(6);
		`CHK("t0_hi", 1'b1, t0)
		apb(1'b1, 12'h27c, 8'h00);
		settle(6);
		`CHK("ssb_an", 1'b1, ssb)
		rchk("a_dat_an", 12'h014, 8'h10);
		// Analog pins stay undriven; bit 4 only pulls low
		apb(1'b1, 12'h014, 8'h00);
		apb(1'b1, 12'h214, 8'h00);
		settle(2);
		`CHK("a_oe_an", 6'h10, a_oe)
		apb(1'b1, 12'h27c, 8'h06);
		apb(1'b1, 12'h014, 8'h3f);
		settle(2);
		`CHK("a_oe_od", 6'h2f, a_oe)
		`CHK("a_out_od", 6'h2f, a_out)
		apb(1'b1, 12'h01c, 8'ha5);
		apb(1'b1, 12'h21c, 8'h00);
		settle(2);
		`CHK("c_oe_out", 8'hff, c_oe)
		`CHK("c_out", 8'ha5, c_out)
		// Whole-register write, never read-modify-write, under override
		apb(1'b1, 12'h21c, 8'hf0);
		sel <= 8'h3c;
		poe <= 8'ha8;
		pdat <= 8'hff;
		settle(3);
		`CHK("c_oe_ovr", 8'h2b, c_oe)
		`CHK("c_out_ovr", 8'h29, c_out & c_oe)
		sel <= 8'h00;
		poe <= 8'h00;
		do_reset;
		`CHK("c_oe_rst2", 8'h00, c_oe)
		apb(1'b1, 12'h21c, 8'h00);
		settle(2);
		`CHK("c_latch_kept", 8'ha5, c_out)
		// Byte lane 0 off: the write must leave direction alone
		pstrb_in <= 4'h0;
		apb(1'b1, 12'h21c, 8'hff);
		pstrb_in <= 4'hf;
		rchk("strb_off", 12'h21c, 8'h00);
		apb(1'b1, 12'h21c, 8'hff);
		c_ext <= 8'h3c;
		// Driver drops one edge late, then sync, filter and output flop
		settle(8);
		`CHK("c_oe_in", 8'h00, c_oe)
		`CHK("plev", 8'h3c, plev)
		rchk("c_dat_in", 12'h01c, 8'h3c);
		complete_run;
	end
endmodule : tb_gpio_ports_a_and_c

bind gpac_ports gpac_ports_properties chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
	.penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .port_a_pin_out(port_a_pin_out), .port_a_pin_oe_out(port_a_pin_oe_out),
	.port_c_pin_out(port_c_pin_out), .port_c_pin_oe_out(port_c_pin_oe_out),
	.periph_select_in(periph_select_in), .periph_oe_in(periph_oe_in), .periph_data_in(periph_data_in),
	.analog_select_out(analog_select_out), .vref_select_out(vref_select_out));
